/* verilog/essn_host.sv */
// Host controller that issues command sequences to a flash whose sector erase is suspended.
// Assumes the flash is already in the erase-suspended state when an operation is requested.
`timescale 1ns/1ps
// Summary of operation
// - In lock state send A0 for set/clear; 90 then 00 exits to erase suspend.
// - Buffer program sends word count minus one, at most 255, at the sector address; 0 or over 256 words refused.
// - Suspend nested program by writing B0 or 51 to any address.
// - In suspended state 30 or 50 resumes; F0, 71, status read keep state.
// - AA at 555 then 55 at 2AA, then resume code restarts nested programming.
module essn_host (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Operation request
  input wire logic i_req,
  input wire logic [3:0] i_op,
  input wire logic i_enhanced,
  input wire logic [11:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic [8:0] i_words,
  input wire logic [11:0] i_sector,
  output logic o_ready,
  output logic o_done,
  output logic o_refused,
  output logic [15:0] o_rdata,
  output logic o_prog_busy,
  output logic o_prog_suspended,
  // Buffer data stream, one word per pulse of o_word_req
  output logic o_word_req,
  input wire logic [15:0] i_word,
  // Flash pins
  output logic [11:0] o_fl_addr,
  output logic [15:0] o_fl_dq_o,
  output logic o_fl_dq_oe,
  input wire logic [15:0] i_fl_dq_i,
  output logic o_fl_we_n,
  output logic o_fl_oe_n
);
  typedef enum logic [2:0] {
    DEV_ERASE_SUSP, DEV_LOCK, DEV_PROG, DEV_SUSP_REQ, DEV_SUSPENDED
  } essn_dev_e;
  typedef enum logic [1:0] {
    H_IDLE, H_ISSUE, H_WAIT, H_PSL
  } essn_ph_e;
  typedef struct packed {
    essn_ph_e ph;
    essn_dev_e dev;
    logic [3:0] op;
    logic [3:0] step;
    logic [8:0] left;
    logic [11:0] addr;
    logic [15:0] data;
    logic [11:0] sector;
    logic enh;
    logic go;
    logic wr;
    logic [11:0] caddr;
    logic [15:0] cdata;
    logic done;
    logic refused;
    logic wreq;
    logic [15:0] rdata;
    logic [19:0] psl;
  } essn_host_s;
  essn_host_s s_q, s_d;

  logic cyc_done;
  logic [15:0] cyc_rdata;

  essn_bus_cycle u_cycle (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_go(s_q.go),
    .i_write(s_q.wr),
    .i_addr(s_q.caddr),
    .i_wdata(s_q.cdata),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_fl_addr(o_fl_addr),
    .o_fl_dq_o(o_fl_dq_o),
    .o_fl_dq_oe(o_fl_dq_oe),
    .i_fl_dq_i(i_fl_dq_i),
    .o_fl_we_n(o_fl_we_n),
    .o_fl_oe_n(o_fl_oe_n)
  );

  // Legality of an operation in the tracked flash state.
  function automatic logic op_ok(input logic [3:0] op, input essn_dev_e dev,
                                 input logic [8:0] words);
    logic ok;
    ok = 1'b0;
    case (op)
      4'(essn_pkg::OP_LOCK_ENTER): ok = (dev == DEV_ERASE_SUSP);
      4'(essn_pkg::OP_LOCK_SETCLR), 4'(essn_pkg::OP_LOCK_EXIT): ok = (dev == DEV_LOCK);
      4'(essn_pkg::OP_WORD_PROG): ok = (dev == DEV_ERASE_SUSP);
      4'(essn_pkg::OP_BUF_PROG):
        ok = (dev == DEV_ERASE_SUSP) && (words != 9'h0) && (words <= essn_pkg::MAX_WORDS);
      4'(essn_pkg::OP_SUSPEND): ok = (dev == DEV_PROG);
      4'(essn_pkg::OP_RESUME), 4'(essn_pkg::OP_RESUME_UNLOCK): ok = (dev == DEV_SUSPENDED);
      4'(essn_pkg::OP_STATUS), 4'(essn_pkg::OP_READ): ok = 1'b1;
      4'(essn_pkg::OP_RESET), 4'(essn_pkg::OP_CLEAR):
        ok = (dev == DEV_LOCK) || (dev == DEV_SUSPENDED) || (dev == DEV_PROG);
      default: ok = 1'b0;
    endcase
    if ((dev == DEV_SUSP_REQ) && (op != 4'(essn_pkg::OP_STATUS))) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : op_ok

  always_comb begin
    s_d = s_q;
    s_d.go = 1'b0;
    s_d.done = 1'b0;
    s_d.refused = 1'b0;
    s_d.wreq = 1'b0;
    case (s_q.ph)
      H_IDLE: begin
        if (i_req) begin
          if (op_ok(i_op, s_q.dev, i_words)) begin
            s_d.ph = H_ISSUE;
            s_d.op = i_op;
            s_d.step = 4'h0;
            s_d.left = i_words;
            s_d.addr = i_addr;
            s_d.data = i_data;
            s_d.sector = i_sector;
            s_d.enh = i_enhanced;
          end else begin
            s_d.refused = 1'b1;
          end
        end
      end
      H_ISSUE: begin
        s_d.go = 1'b1;
        s_d.wr = 1'b1;
        s_d.ph = H_WAIT;
        s_d.caddr = essn_pkg::ADDR_UNLOCK1;
        s_d.cdata = 16'h0;
        case (s_q.op)
          4'(essn_pkg::OP_LOCK_ENTER), 4'(essn_pkg::OP_WORD_PROG),
          4'(essn_pkg::OP_BUF_PROG), 4'(essn_pkg::OP_RESUME_UNLOCK): begin
            // Every prefixed command opens with the two unlock writes.
            if (s_q.step == 4'h0) begin
              s_d.cdata = {8'h0, essn_pkg::CMD_UNLOCK1};
            end else if (s_q.step == 4'h1) begin
              s_d.caddr = essn_pkg::ADDR_UNLOCK2;
              s_d.cdata = {8'h0, essn_pkg::CMD_UNLOCK2};
            end else begin
              case (s_q.op)
                4'(essn_pkg::OP_LOCK_ENTER): begin
                  s_d.cdata = {8'h0, 8'he0};
                end
                4'(essn_pkg::OP_WORD_PROG): begin
                  if (s_q.step == 4'h2) begin
                    s_d.cdata = {8'h0, essn_pkg::CMD_WORD_PROG};
                  end else begin
                    s_d.caddr = s_q.addr;
                    s_d.cdata = s_q.data;
                  end
                end
                4'(essn_pkg::OP_BUF_PROG): begin
                  s_d.caddr = s_q.sector;
                  if (s_q.step == 4'h2) begin
                    s_d.cdata = {8'h0, essn_pkg::CMD_BUF_LOAD};
                  end else if (s_q.step == 4'h3) begin
                    s_d.cdata = 16'(s_q.left - 9'h1);
                  end else if (s_q.step == 4'h4) begin
                    s_d.caddr = s_q.sector;
                    s_d.cdata = i_word;
                  end else begin
                    s_d.cdata = {8'h0, essn_pkg::CMD_BUF_CONFIRM};
                  end
                end
                default: begin
                  s_d.caddr = 12'h0;
                  s_d.cdata = {8'h0, s_q.enh ? essn_pkg::CMD_RES_ENH
                                             : essn_pkg::CMD_RES_LEGACY};
                end
              endcase
            end
          end
          4'(essn_pkg::OP_LOCK_SETCLR): begin
            if (s_q.step == 4'h0) begin
              s_d.caddr = 12'h0;
              s_d.cdata = {8'h0, essn_pkg::CMD_LOCK_SETCLR};
            end else begin
              s_d.caddr = s_q.addr;
              s_d.cdata = s_q.data;
            end
          end
          4'(essn_pkg::OP_LOCK_EXIT): begin
            s_d.caddr = 12'h0;
            s_d.cdata = {8'h0, (s_q.step == 4'h0) ? essn_pkg::CMD_EXIT_ENTRY
                                                  : essn_pkg::CMD_EXIT};
          end
          4'(essn_pkg::OP_SUSPEND): begin
            s_d.caddr = s_q.addr;
            s_d.cdata = {8'h0, s_q.enh ? essn_pkg::CMD_SUSP_ENH
                                       : essn_pkg::CMD_SUSP_LEGACY};
          end
          4'(essn_pkg::OP_RESUME): begin
            s_d.caddr = 12'h0;
            s_d.cdata = {8'h0, s_q.enh ? essn_pkg::CMD_RES_ENH
                                       : essn_pkg::CMD_RES_LEGACY};
          end
          4'(essn_pkg::OP_STATUS): begin
            if (s_q.step == 4'h0) begin
              s_d.cdata = {8'h0, essn_pkg::CMD_SR_READ};
            end else begin
              s_d.wr = 1'b0;
              s_d.caddr = s_q.addr;
            end
          end
          4'(essn_pkg::OP_RESET): begin
            s_d.caddr = 12'h0;
            s_d.cdata = {8'h0, essn_pkg::CMD_RESET};
          end
          4'(essn_pkg::OP_CLEAR): begin
            s_d.cdata = {8'h0, essn_pkg::CMD_SR_CLEAR};
          end
          default: begin
            s_d.wr = 1'b0;
            s_d.caddr = s_q.addr;
          end
        endcase
      end
      H_WAIT: begin
        if (cyc_done) begin
          s_d.ph = H_ISSUE;
          s_d.step = s_q.step + 4'h1;
          if ((s_q.op == 4'(essn_pkg::OP_BUF_PROG)) && (s_q.step == 4'h4)) begin
            s_d.wreq = 1'b1;
            s_d.left = s_q.left - 9'h1;
            if (s_q.left != 9'h1) begin
              s_d.step = 4'h4;
            end
          end
          if (last_step(s_q.op, s_q.step, s_q.left)) begin
            s_d.ph = H_IDLE;
            s_d.done = 1'b1;
            s_d.rdata = cyc_rdata;
            s_d.dev = next_dev(s_q.op, s_q.dev, cyc_rdata[essn_pkg::STATUS_READY_POS]);
            if (s_q.op == 4'(essn_pkg::OP_SUSPEND)) begin
              s_d.ph = H_PSL;
              s_d.done = 1'b0;
              s_d.psl = 20'(essn_pkg::PSL_CYC);
            end
          end
        end
      end
      H_PSL: begin
        // No request, not even a status read, is taken while the latency runs out.
        if (s_q.psl == 20'h0) begin
          s_d.ph = H_IDLE;
          s_d.done = 1'b1;
          s_d.dev = DEV_SUSPENDED;
        end else begin
          s_d.psl = s_q.psl - 20'h1;
        end
      end
      default: s_d.ph = H_IDLE;
    endcase
  end

  function automatic logic last_step(input logic [3:0] op, input logic [3:0] step,
                                     input logic [8:0] left);
    logic r;
    r = 1'b0;
    case (op)
      4'(essn_pkg::OP_LOCK_ENTER), 4'(essn_pkg::OP_RESUME_UNLOCK): r = (step == 4'h2);
      4'(essn_pkg::OP_WORD_PROG): r = (step == 4'h3);
      4'(essn_pkg::OP_BUF_PROG): r = (step == 4'h5);
      4'(essn_pkg::OP_LOCK_SETCLR), 4'(essn_pkg::OP_LOCK_EXIT),
      4'(essn_pkg::OP_STATUS): r = (step == 4'h1);
      default: r = 1'b1;
    endcase
    if ((op == 4'(essn_pkg::OP_BUF_PROG)) && (left == 9'h0)) begin
      r = 1'b1;
    end
    return r;
  endfunction : last_step

  function automatic essn_dev_e next_dev(input logic [3:0] op, input essn_dev_e dev,
                                         input logic rdy);
    essn_dev_e n;
    n = dev;
    case (op)
      4'(essn_pkg::OP_LOCK_ENTER): n = DEV_LOCK;
      4'(essn_pkg::OP_LOCK_EXIT): n = DEV_ERASE_SUSP;
      4'(essn_pkg::OP_WORD_PROG), 4'(essn_pkg::OP_BUF_PROG): n = DEV_PROG;
      4'(essn_pkg::OP_SUSPEND): n = DEV_SUSP_REQ;
      4'(essn_pkg::OP_RESUME), 4'(essn_pkg::OP_RESUME_UNLOCK): n = DEV_PROG;
      4'(essn_pkg::OP_RESET), 4'(essn_pkg::OP_CLEAR):
        n = (dev == DEV_LOCK && op == 4'(essn_pkg::OP_CLEAR)) ? DEV_LOCK
          : (dev == DEV_SUSPENDED) ? DEV_SUSPENDED : DEV_ERASE_SUSP;
      4'(essn_pkg::OP_STATUS):
        n = (dev == DEV_PROG && rdy) ? DEV_PROG : dev;
      default: n = dev;
    endcase
    return n;
  endfunction : next_dev

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ready = (s_q.ph == H_IDLE);
  assign o_done = s_q.done;
  assign o_refused = s_q.refused;
  assign o_rdata = s_q.rdata;
  assign o_prog_busy = (s_q.dev == DEV_PROG);
  assign o_prog_suspended = (s_q.dev == DEV_SUSPENDED);
  assign o_word_req = s_q.wreq;
endmodule : essn_host

/* verilog/essn_pkg.sv */
// Package for the host-side controller of a flash nested-program-in-erase-suspend sequence.
// Assumes a 16-bit flash data bus, word addressing and one 40 MHz clock.
package essn_pkg;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2aa;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_SR_READ = 8'h70;
  localparam logic [7:0] CMD_SR_CLEAR = 8'h71;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_LOCK_SETCLR = 8'ha0;
  localparam logic [7:0] CMD_EXIT_ENTRY = 8'h90;
  localparam logic [7:0] CMD_EXIT = 8'h00;
  localparam logic [7:0] CMD_WORD_PROG = 8'ha0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] CMD_SUSP_LEGACY = 8'hb0;
  localparam logic [7:0] CMD_SUSP_ENH = 8'h51;
  localparam logic [7:0] CMD_RES_LEGACY = 8'h30;
  localparam logic [7:0] CMD_RES_ENH = 8'h50;
  localparam logic [8:0] MAX_WORDS = 9'd256;
  localparam int STATUS_READY_POS = 7;
  // Bus cycle timing at 40 MHz.
  localparam int CLK_NS = 25;
  localparam int WE_PULSE_NS = 50;
  localparam int WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACCESS_NS = 100;
  localparam int RD_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int PSL_US = 40;
  localparam int PSL_CYC = PSL_US * 1000 / CLK_NS;

  typedef enum logic [3:0] {
    OP_LOCK_ENTER, OP_LOCK_SETCLR, OP_LOCK_EXIT, OP_WORD_PROG, OP_BUF_PROG,
    OP_SUSPEND, OP_RESUME, OP_RESUME_UNLOCK, OP_STATUS, OP_RESET, OP_CLEAR, OP_READ
  } essn_op_e;
endpackage : essn_pkg

/* verilog/essn_bus_cycle.sv */
// One flash bus cycle engine: a write or a read, strobes held for fixed counts.
// Assumes the flash samples on the rising edge of write enable and drives data after the read count.
`timescale 1ns/1ps
module essn_bus_cycle (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Request
  input wire logic i_go,
  input wire logic i_write,
  input wire logic [11:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_done,
  output logic [15:0] o_rdata,
  // Flash pins
  output logic [11:0] o_fl_addr,
  output logic [15:0] o_fl_dq_o,
  output logic o_fl_dq_oe,
  input wire logic [15:0] i_fl_dq_i,
  output logic o_fl_we_n,
  output logic o_fl_oe_n
);
  typedef struct packed {
    logic busy;
    logic wr;
    logic [3:0] cnt;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
  } essn_cyc_s;
  essn_cyc_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy) begin
      if (i_go) begin
        s_d.busy = 1'b1;
        s_d.wr = i_write;
        s_d.addr = i_addr;
        s_d.wdata = i_wdata;
        s_d.cnt = i_write ? 4'(essn_pkg::WE_CYC) : 4'(essn_pkg::RD_CYC);
      end
    end else if (s_q.cnt == 4'h0) begin
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      // The flash data is a response to our own strobe, so it is settled by now.
      if (!s_q.wr) begin
        s_d.rdata = i_fl_dq_i;
      end
    end else begin
      s_d.cnt = s_q.cnt - 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_done = s_q.done;
  assign o_rdata = s_q.rdata;
  assign o_fl_addr = s_q.addr;
  assign o_fl_dq_o = s_q.wdata;
  assign o_fl_dq_oe = s_q.busy & s_q.wr;
  assign o_fl_we_n = ~(s_q.busy & s_q.wr & (s_q.cnt != 4'h0));
  assign o_fl_oe_n = ~(s_q.busy & ~s_q.wr);
endmodule : essn_bus_cycle

/* verif/esn.sv */
// State codes of the behavioural flash model, shared with the bench.
// Assumes nothing beyond a SystemVerilog compiler.
package esn;
  typedef enum logic [4:0] {
    IDLE, U1, U2, LK, BSY, SRQ, SUS, V1, V2, LKS, LKX, CNT, DAT, CNF, P1, STA
  } esn_st_e;
endpackage : esn

/* verif/essn_flash_model.sv */
// Behavioural flash with its sector erase suspended, seen through its pins.
// Assumes writes latch on the rising write enable and reads on a low output enable.
`timescale 1ns/1ps
module essn_flash_model (
  // Clock
  input wire logic i_ref_clk,
  // Flash pins
  input wire logic [11:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  output logic [15:0] o_dq = 16'h0000
);
  esn::esn_st_e st_q = esn::IDLE;
  esn::esn_st_e ret_q = esn::IDLE;
  logic we_q = 1'b1, oe_q = 1'b1, u1;
  logic [11:0] wa = 12'h000, sec_q = 12'h000;
  logic [15:0] wd = 16'h0000;
  logic [7:0] d;
  logic [8:0] left_q = 9'h000, got_q = 9'h000;
  int busy_q = 0, lat_q = 0;
  wire rdy = busy_q == 0;
  wire [15:0] rd = (st_q == esn::STA) ? {8'h00, rdy, 7'h00} : {4'h0, i_addr} ^ 16'h5a00;
  task automatic go_busy();
    st_q = esn::BSY;
    busy_q = 300;
  endtask : go_busy
  always @(posedge i_ref_clk) begin
    if (!i_we_n) begin
      wa = i_addr;
      wd = i_dq;
    end
    d = wd[7:0];
    u1 = wa == 12'h555;
    if (i_we_n && !we_q) begin
      if (d == 8'h70 && u1 && st_q <= esn::V2) begin
        ret_q = st_q inside {esn::U1, esn::U2} ? esn::IDLE :
                st_q inside {esn::V1, esn::V2} ? esn::SUS : st_q;
        st_q = esn::STA;
      end else begin
        case (st_q)
          esn::IDLE: if (d == 8'haa && u1) st_q = esn::U1;
          esn::U1: if (d == 8'h55 && wa == 12'h2aa) st_q = esn::U2;
          esn::U2: begin
            if (d == 8'ha0 && u1) st_q = esn::P1;
            else if (d == 8'he0 && u1) st_q = esn::LK;
            else if (d == 8'h25) begin
              st_q = esn::CNT;
              sec_q = wa;
            end else if (d == 8'hf0) st_q = esn::IDLE;
          end
          esn::LK: begin
            if (d == 8'hf0) st_q = esn::IDLE;
            else if (d == 8'h90) st_q = esn::LKX;
            else if (d == 8'ha0) st_q = esn::LKS;
          end
          esn::LKS: st_q = esn::LK;
          esn::LKX: if (d == 8'h00) st_q = esn::IDLE;
          esn::CNT: begin
            if (wd <= 16'h00ff && wa == sec_q) begin
              left_q = wd[8:0];
              got_q = 9'h000;
              st_q = esn::DAT;
            end else go_busy();
          end
          esn::DAT: begin
            got_q++;
            if (left_q == 9'h000) st_q = esn::CNF;
            else left_q--;
          end
          esn::CNF: if (d == 8'h29) go_busy();
          esn::P1: go_busy();
          esn::BSY: begin
            if (!rdy && (d == 8'hb0 || d == 8'h51)) begin
              st_q = esn::SRQ;
              lat_q = 100;
            end else if (rdy && (d == 8'hf0 || d == 8'h71)) st_q = esn::IDLE;
            else if (rdy && d == 8'haa && u1) st_q = esn::U1;
          end
          esn::SUS: begin
            if (d == 8'haa && u1) st_q = esn::V1;
            else if (d == 8'h30 || d == 8'h50) st_q = esn::BSY;
          end
          esn::V1: if (d == 8'h55 && wa == 12'h2aa) st_q = esn::V2;
          esn::V2: if (d == 8'h30 || d == 8'h50) st_q = esn::BSY;
          default: ;
        endcase
      end
    end
    if (i_oe_n && !oe_q && st_q == esn::STA) st_q = ret_q;
    if (st_q == esn::BSY && busy_q > 0) busy_q--;
    if (st_q == esn::SRQ) begin
      if (lat_q == 0) st_q = esn::SUS;
      else lat_q--;
    end
    // A released bus toggles so that a stale value is never mistaken for data.
    o_dq <= i_oe_n ? ~o_dq : rd;
    we_q = i_we_n;
    oe_q = i_oe_n;
  end
endmodule : essn_flash_model

/* verif/essn_host_properties.sv */
// Concurrent checks on the host controller's request and flash pins.
// Assumes it is bound into the controller and sees its ports only.
`timescale 1ns/1ps
module essn_host_props (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Request side
  input wire logic i_req,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_refused,
  // Flash pins
  input wire logic [11:0] o_fl_addr,
  input wire logic [15:0] o_fl_dq_o,
  input wire logic o_fl_dq_oe,
  input wire logic o_fl_we_n,
  input wire logic o_fl_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  refuse_pulse_a: assert property (o_refused |=> !o_refused)
    else $error("refused held");
  refuse_cause_a: assert property (o_refused |-> $past(i_req && o_ready))
    else $error("refused without request");
  refuse_quiet_a: assert property (o_refused |-> o_fl_we_n && o_fl_oe_n)
    else $error("bus cycle on refusal");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done held");
  strobe_excl_a: assert property (!(!o_fl_we_n && !o_fl_oe_n))
    else $error("both strobes low");
  read_float_a: assert property (!o_fl_oe_n |-> !o_fl_dq_oe)
    else $error("driving during read");
  we_width_a: assert property ($fell(o_fl_we_n) |-> !o_fl_we_n [*2] ##1 o_fl_we_n)
    else $error("write pulse width");
  rd_width_a: assert property ($fell(o_fl_oe_n) |-> !o_fl_oe_n [*5] ##1 o_fl_oe_n)
    else $error("read pulse width");
  wr_stable_a: assert property (!o_fl_we_n && !$fell(o_fl_we_n) |->
    $stable(o_fl_addr) && $stable(o_fl_dq_o) && o_fl_dq_oe) else $error("write moved");
endmodule : essn_host_props

/* verif/essn_host_tb.sv */
// Self-checking bench for the erase-suspend nested-program host controller.
// Assumes the flash model starts with its sector erase suspended.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module essn_host_tb;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, req = 1'b0, enh = 1'b0, r;
  logic [3:0] op = 4'h0;
  logic [11:0] addr = 12'h000, sec = 12'h000, fa;
  logic [15:0] data = 16'h0000, word = 16'h0000, rdata, dq_o, md, dq_w;
  logic [8:0] words = 9'h001;
  logic rdy, done, refd, pbusy, psusp, wreq, dq_oe, we_n, oe_n;
  int miscompares = 0, tests_run = 0, cyc = 0;
  assign dq_w = dq_oe ? dq_o : md;
  essn_host uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(req), .i_op(op),
    .i_enhanced(enh), .i_addr(addr), .i_data(data), .i_words(words), .i_sector(sec),
    .o_ready(rdy), .o_done(done), .o_refused(refd), .o_rdata(rdata), .o_prog_busy(pbusy),
    .o_prog_suspended(psusp), .o_word_req(wreq), .i_word(word), .o_fl_addr(fa),
    .o_fl_dq_o(dq_o), .o_fl_dq_oe(dq_oe), .i_fl_dq_i(dq_w), .o_fl_we_n(we_n),
    .o_fl_oe_n(oe_n));
  essn_flash_model m (.i_ref_clk(i_ref_clk), .i_addr(fa), .i_dq(dq_w), .i_we_n(we_n),
    .i_oe_n(oe_n), .o_dq(md));
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  always @(negedge i_ref_clk) if (wreq) word <= word + 16'h0001;
  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic do_op(input logic [3:0] o, input logic e, input logic [8:0] n);
    int k;
    @(negedge i_ref_clk);
    for (k = 0; k < 3000 && rdy !== 1'b1; k++) @(negedge i_ref_clk);
    op = o;
    enh = e;
    words = n;
    req = 1'b1;
    @(negedge i_ref_clk);
    req = 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1 && refd !== 1'b1; k++) @(negedge i_ref_clk);
    r = refd;
  endtask : do_op
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      do_op(essn_pkg::OP_STATUS, 1'b0, 9'h001);
      k++;
    end while (rdata[7] !== 1'b1 && k < 60);
    `CHK(rdata, 16'h0080)
  endtask : wait_ready
  task automatic t_idle();
    do_op(essn_pkg::OP_SUSPEND, 1'b0, 9'h001);
    `CHK(r, 1'b1)
    do_op(essn_pkg::OP_RESUME, 1'b1, 9'h001);
    `CHK(r, 1'b1)
    addr = 12'h3c5;
    do_op(essn_pkg::OP_READ, 1'b0, 9'h001);
    `CHK(rdata, 16'h59c5)
    `CHK(m.st_q, esn::IDLE)
    $display("t_idle done");
  endtask : t_idle
  task automatic t_lock();
    do_op(essn_pkg::OP_LOCK_ENTER, 1'b0, 9'h001);
    `CHK(m.st_q, esn::LK)
    do_op(essn_pkg::OP_STATUS, 1'b0, 9'h001);
    `CHK(rdata, 16'h0080)
    `CHK(m.st_q, esn::LK)
    do_op(essn_pkg::OP_CLEAR, 1'b0, 9'h001);
    `CHK(m.st_q, esn::LK)
    data = 16'h0001;
    do_op(essn_pkg::OP_LOCK_SETCLR, 1'b0, 9'h001);
    `CHK(m.st_q, esn::LK)
    do_op(essn_pkg::OP_LOCK_EXIT, 1'b0, 9'h001);
    `CHK(m.st_q, esn::IDLE)
    do_op(essn_pkg::OP_LOCK_ENTER, 1'b0, 9'h001);
    do_op(essn_pkg::OP_RESET, 1'b0, 9'h001);
    `CHK(m.st_q, esn::IDLE)
    $display("t_lock done");
  endtask : t_lock
  task automatic t_nested();
    addr = 12'h040;
    data = 16'h1234;
    do_op(essn_pkg::OP_WORD_PROG, 1'b0, 9'h001);
    `CHK(m.st_q, esn::BSY)
    `CHK(pbusy, 1'b1)
    do_op(essn_pkg::OP_SUSPEND, 1'b0, 9'h001);
    `CHK(r, 1'b0)
    `CHK(m.st_q, esn::SUS)
    `CHK(psusp, 1'b1)
    do_op(essn_pkg::OP_CLEAR, 1'b0, 9'h001);
    do_op(essn_pkg::OP_RESET, 1'b0, 9'h001);
    do_op(essn_pkg::OP_STATUS, 1'b0, 9'h001);
    `CHK(m.st_q, esn::SUS)
    do_op(essn_pkg::OP_RESUME, 1'b0, 9'h001);
    `CHK(m.st_q, esn::BSY)
    do_op(essn_pkg::OP_SUSPEND, 1'b1, 9'h001);
    `CHK(m.st_q, esn::SUS)
    do_op(essn_pkg::OP_RESUME_UNLOCK, 1'b1, 9'h001);
    `CHK(m.st_q, esn::BSY)
    wait_ready();
    do_op(essn_pkg::OP_RESET, 1'b0, 9'h001);
    `CHK(m.st_q, esn::IDLE)
    $display("t_nested done");
  endtask : t_nested
  task automatic t_buf();
    sec = 12'h800;
    addr = 12'h800;
    do_op(essn_pkg::OP_BUF_PROG, 1'b0, 9'd256);
    `CHK(r, 1'b0)
    `CHK(m.got_q, 9'd256)
    `CHK(word, 16'h0100)
    `CHK(m.st_q, esn::BSY)
    wait_ready();
    do_op(essn_pkg::OP_CLEAR, 1'b0, 9'h001);
    `CHK(m.st_q, esn::IDLE)
    do_op(essn_pkg::OP_BUF_PROG, 1'b0, 9'd257);
    `CHK(r, 1'b1)
    do_op(essn_pkg::OP_BUF_PROG, 1'b0, 9'd0);
    `CHK(r, 1'b1)
    `CHK(m.st_q, esn::IDLE)
    $display("t_buf done");
  endtask : t_buf
  initial begin
    repeat (8) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    t_idle();
    t_lock();
    t_nested();
    t_buf();
    end_sim();
  end
endmodule : essn_host_tb
bind essn_host essn_host_props chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_req(i_req), .o_ready(o_ready), .o_done(o_done), .o_refused(o_refused),
  .o_fl_addr(o_fl_addr), .o_fl_dq_o(o_fl_dq_o), .o_fl_dq_oe(o_fl_dq_oe),
  .o_fl_we_n(o_fl_we_n), .o_fl_oe_n(o_fl_oe_n));
